// ### core/bdsc_pkg.sv
// Purpose: shared constants and types of the background debug status/control block
// Assumes: one 200 MHz clock, serial command decode done upstream
// Notes:   field positions and reset values of the status/control byte live here
package bdsc_pkg;

    // status/control byte layout
    localparam int BDSC_CTRL_W          = 8;   // status/control width
    localparam int BDSC_BKPT_W          = 16;  // breakpoint match width
    localparam int BDSC_BIT_PERMIT      = 7;   // background_permit
    localparam int BDSC_BIT_ACTIVE      = 6;   // background_active
    localparam int BDSC_BIT_BKPT_EN     = 5;   // breakpoint_enable
    localparam int BDSC_BIT_FORCE_TAG   = 4;   // force_tag_select
    localparam int BDSC_BIT_CLK_SEL     = 3;   // link_clock_select
    localparam int BDSC_BIT_WAIT_STOP   = 2;   // wait_stop_state
    localparam int BDSC_BIT_WS_FAIL     = 1;   // wait_stop_failure
    localparam int BDSC_BIT_SLOW_FAIL   = 0;   // slow_access_failure

    // reset values
    localparam logic [7:0]  BDSC_CTRL_RESET = 8'h00;
    localparam logic [15:0] BDSC_BKPT_RESET = 16'h0000;

    // alternate link clock divider, in mclk cycles per tick
    localparam int BDSC_ALT_DIV         = 4;

    // serial commands as handed over by the serial engine
    typedef enum logic [2:0] {
        BDSC_CMD_NONE,
        BDSC_CMD_STATUS_READ,
        BDSC_CMD_CONTROL_WRITE,
        BDSC_CMD_BKPT_READ,
        BDSC_CMD_BKPT_WRITE,
        BDSC_CMD_BACKGROUND,
        BDSC_CMD_GO
    } bdsc_cmd_t;

    // cpu mode as seen by the debug controller
    typedef enum logic [1:0] {
        BDSC_MODE_RUN,
        BDSC_MODE_ENTERING,
        BDSC_MODE_BACKGROUND
    } bdsc_mode_t;

endpackage : bdsc_pkg

// ### core/bdsc_link_tick.sv
// Purpose: one-cycle enable for the serial link bit clock
// Assumes: bus clock is mclk itself, the alternate source is a divided mclk
// Notes:   selection may change at any time; the divider runs on and keeps its phase
`timescale 1ns/1ps
`default_nettype none
module bdsc_link_tick
    import bdsc_pkg::*;
#(
    parameter int DIV = BDSC_ALT_DIV   // alternate source divide ratio
) (
    input  wire logic mclk,          // system clock
    input  wire logic rst,           // synchronous reset, active high
    input  wire logic bus_sel,       // 1 selects bus clock, 0 alternate
    output var  logic tick_q         // link clock enable pulse
);
    localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);

    logic [CW-1:0] cnt_q;            // alternate divider count

    // divider runs always so the alternate tick has a steady phase
    always_ff @(posedge mclk) begin
        if (rst || cnt_q == LAST) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    // bus clock gives a tick every cycle, alternate one every DIV cycles
    always_ff @(posedge mclk) begin
        if (rst) begin
            tick_q <= 1'b0;
        end else begin
            tick_q <= bus_sel | (cnt_q == LAST);
        end
    end
endmodule : bdsc_link_tick
`default_nettype wire

// ### core/bdsc_bkpt_match.sv
// Purpose: compare the cpu address bus with the breakpoint match address
// Assumes: cpu_addr is valid while addr_valid is high
// Notes:   result is registered, one cycle behind the address
`timescale 1ns/1ps
`default_nettype none
module bdsc_bkpt_match
    import bdsc_pkg::*;
#(
    parameter int AW = BDSC_BKPT_W    // address width
) (
    input  wire logic          mclk,        // system clock
    input  wire logic          rst,         // synchronous reset
    input  wire logic          enable,      // breakpoint enabled
    input  wire logic          addr_valid,  // address bus cycle
    input  wire logic          opfetch,     // cycle is an opcode fetch
    input  wire logic [AW-1:0] addr,        // cpu address
    input  wire logic [AW-1:0] match_addr,  // breakpoint address
    output var  logic          hit_q,       // any matching cycle
    output var  logic          hit_op_q     // matching opcode fetch
);
    logic eq;   // raw compare, gated by enable so a disabled match is ignored
    assign eq = enable & addr_valid & (addr == match_addr);

    // register both flavours of hit for the caller
    always_ff @(posedge mclk) begin
        if (rst) begin
            hit_q    <= 1'b0;
            hit_op_q <= 1'b0;
        end else begin
            hit_q    <= eq;
            hit_op_q <= eq & opfetch;
        end
    end
endmodule : bdsc_bkpt_match
`default_nettype wire

// ### core/bdsc_ctrl.sv
// Purpose: status/control byte and breakpoint match address of the background
//          debug controller, plus entry into and exit from active background mode
// Assumes: serial command framing is decoded upstream into one-cycle commands
// Notes:   registers have no address; only serial commands reach them
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - status byte and breakpoint address, serial only
// - no memory address, no user program access
// - status-read reads, control-write writes status byte
// - permit bit frozen while background mode active
// - four status bits never written by commands
// - permit bit gates background mode, reset clears
// - active bit shows background mode in progress
// - enable bit gates breakpoint, else ignored
// - force select: match forces background at boundary
// - tag select: tagged opcode retires into background
// - clock select free access, reset selects alternate
// - breakpoint read/write and go commands refused during wait or stop unless background mode is active
// - background command wakes cpu from wait/stop
// - wait/stop bit shows wait/stop or wake-up
// - failure bit set on wait/stop access clash
// - slow access failure bit unused, reads zero
// - breakpoint address via its own serial commands
module bdsc_ctrl
    import bdsc_pkg::*;
#(
    parameter int AW      = BDSC_BKPT_W,   // address width
    parameter int ALT_DIV = BDSC_ALT_DIV   // alternate link clock divide
) (
    input  wire logic            mclk,            // system clock, 200 MHz
    input  wire logic            rst,             // synchronous reset, active high
    input  wire bdsc_cmd_t       cmd,             // serial command, one cycle
    input  wire logic [AW-1:0]   cmd_wdata,       // write data of the command
    input  wire logic            mem_ws_fail,     // memory command clashed with wait/stop
    input  wire logic            mem_cmd_start,   // a memory access command starts
    input  wire logic            cpu_wait_stop,   // cpu sits in wait or stop
    input  wire logic            cpu_addr_valid,  // cpu bus cycle
    input  wire logic            cpu_opfetch,     // cycle is an opcode fetch
    input  wire logic [AW-1:0]   cpu_addr,        // cpu address bus
    input  wire logic            cpu_boundary,    // instruction boundary
    input  wire logic            cpu_tag_retire,  // tagged opcode reached queue end
    input  wire logic            cpu_bgnd_exec,   // cpu executes background opcode
    input  wire logic            cpu_bdm_ack,     // cpu has halted for background
    output var  logic            rsp_valid_q,     // read answer strobe
    output var  logic [AW-1:0]   rsp_data_q,      // read answer data
    output var  logic            cmd_refused_q,   // command not executed
    output var  logic            bdm_req_q,       // ask cpu to enter background
    output var  logic            swi_req_q,       // break taken as software interrupt
    output var  logic            resume_q,        // return to user program
    output var  logic            tag_req_q,       // tag the fetched opcode
    output var  logic            bdm_active_q,    // background mode active
    output var  logic            link_tick_q      // serial link bit enable
);

    // --- register state ---
    logic            permit_q;      // background_permit
    logic            bkpt_en_q;     // breakpoint_enable
    logic            force_tag_q;   // force_tag_select
    logic            clk_sel_q;     // link_clock_select
    logic            ws_wake_q;     // woken out of wait/stop into background
    logic            ws_fail_q;     // wait_stop_failure
    logic [AW-1:0]   bkpt_q;        // breakpoint_match_address
    bdsc_mode_t      mode_q;        // run, entering or background
    logic            force_pend_q;  // force match waiting for boundary
    logic [7:0]      status;        // assembled status/control byte

    // --- derived strobes ---
    logic            hit;           // any matching bus cycle
    logic            hit_op;        // matching opcode fetch
    logic            ws_now;        // wait_stop_state as read
    logic            in_bg;         // background mode active
    logic            refuse;        // command falls in the wait/stop gap
    logic            do_ctrl_wr;    // accepted control-write
    logic            do_bkpt_wr;    // accepted breakpoint write
    logic            do_bgnd_cmd;   // accepted background command
    logic            do_go;         // accepted go command
    logic            brk_event;     // breakpoint or opcode wants background
    logic            enter;         // permitted entry this cycle

    assign in_bg  = (mode_q == BDSC_MODE_BACKGROUND);
    // bit 2 covers both live wait/stop and a wake into background
    assign ws_now = cpu_wait_stop | ws_wake_q;

    // in wait/stop only status read, control write and background run;
    // memory and breakpoint traffic would hang on a sleeping bus
    assign refuse = cpu_wait_stop & ~in_bg
                  & (cmd == BDSC_CMD_BKPT_READ || cmd == BDSC_CMD_BKPT_WRITE
                     || cmd == BDSC_CMD_GO);

    assign do_ctrl_wr  = (cmd == BDSC_CMD_CONTROL_WRITE);
    assign do_bkpt_wr  = (cmd == BDSC_CMD_BKPT_WRITE) & ~refuse;
    assign do_bgnd_cmd = (cmd == BDSC_CMD_BACKGROUND);
    assign do_go       = (cmd == BDSC_CMD_GO) & ~refuse & in_bg;

    // breakpoint sources; a disabled breakpoint never reaches here
    assign brk_event = (force_pend_q & cpu_boundary)
                     | cpu_tag_retire
                     | cpu_bgnd_exec;
    // background command needs permit too; otherwise nothing happens
    assign enter = permit_q & (mode_q == BDSC_MODE_RUN)
                 & (brk_event | do_bgnd_cmd);

    // status byte as read; slow access failure has no source here
    always_comb begin
        status                     = BDSC_CTRL_RESET;
        status[BDSC_BIT_PERMIT]    = permit_q;
        status[BDSC_BIT_ACTIVE]    = in_bg;
        status[BDSC_BIT_BKPT_EN]   = bkpt_en_q;
        status[BDSC_BIT_FORCE_TAG] = force_tag_q;
        status[BDSC_BIT_CLK_SEL]   = clk_sel_q;
        status[BDSC_BIT_WAIT_STOP] = ws_now;
        status[BDSC_BIT_WS_FAIL]   = ws_fail_q;
        status[BDSC_BIT_SLOW_FAIL] = 1'b0;
    end

    // address compare, gated by the enable bit
    bdsc_bkpt_match #(
        .AW         (AW)
    ) u_match (
        .mclk       (mclk),
        .rst        (rst),
        .enable     (bkpt_en_q),
        .addr_valid (cpu_addr_valid),
        .opfetch    (cpu_opfetch),
        .addr       (cpu_addr),
        .match_addr (bkpt_q),
        .hit_q      (hit),
        .hit_op_q   (hit_op)
    );

    // serial link bit enable, bus clock or divided alternate
    bdsc_link_tick #(
        .DIV     (ALT_DIV)
    ) u_tick (
        .mclk    (mclk),
        .rst     (rst),
        .bus_sel (clk_sel_q),
        .tick_q  (link_tick_q)
    );

    // control bits: only writable by the control-write command, never by
    // a cpu bus cycle, since the block has no port on the cpu data bus
    always_ff @(posedge mclk) begin
        if (rst) begin
            permit_q    <= BDSC_CTRL_RESET[BDSC_BIT_PERMIT];
            bkpt_en_q   <= BDSC_CTRL_RESET[BDSC_BIT_BKPT_EN];
            force_tag_q <= BDSC_CTRL_RESET[BDSC_BIT_FORCE_TAG];
            clk_sel_q   <= BDSC_CTRL_RESET[BDSC_BIT_CLK_SEL];
        end else if (do_ctrl_wr) begin
            // permit held while active, so it cannot forbid a mode in progress
            if (!in_bg) begin
                permit_q <= cmd_wdata[BDSC_BIT_PERMIT];
            end
            bkpt_en_q   <= cmd_wdata[BDSC_BIT_BKPT_EN];
            force_tag_q <= cmd_wdata[BDSC_BIT_FORCE_TAG];
            clk_sel_q   <= cmd_wdata[BDSC_BIT_CLK_SEL];
            // bits 6, 2, 1, 0 of the write data are dropped here
        end
    end

    // breakpoint match address, written only by its own command
    always_ff @(posedge mclk) begin
        if (rst) begin
            bkpt_q <= BDSC_BKPT_RESET;
        end else if (do_bkpt_wr) begin
            bkpt_q <= cmd_wdata;
        end
    end

    // read answers one cycle after the command; refusals answer nothing
    always_ff @(posedge mclk) begin
        if (rst) begin
            rsp_valid_q <= 1'b0;
            rsp_data_q  <= '0;
        end else if (cmd == BDSC_CMD_STATUS_READ) begin
            rsp_valid_q <= 1'b1;
            rsp_data_q  <= AW'(status);
        end else if (cmd == BDSC_CMD_BKPT_READ && !refuse) begin
            rsp_valid_q <= 1'b1;
            rsp_data_q  <= bkpt_q;
        end else begin
            rsp_valid_q <= 1'b0;
        end
    end

    // refusal strobe for the serial engine
    always_ff @(posedge mclk) begin
        if (rst) begin
            cmd_refused_q <= 1'b0;
        end else begin
            cmd_refused_q <= refuse;
        end
    end

    // force flavour: remember a match until the instruction ends;
    // the address need not be an opcode
    always_ff @(posedge mclk) begin
        if (rst || !bkpt_en_q || mode_q != BDSC_MODE_RUN) begin
            force_pend_q <= 1'b0;
        end else if (hit && force_tag_q) begin
            force_pend_q <= 1'b1;
        end else if (cpu_boundary) begin
            force_pend_q <= 1'b0;
        end
    end

    // tag flavour: mark the fetched opcode; the cpu queue carries it
    always_ff @(posedge mclk) begin
        if (rst) begin
            tag_req_q <= 1'b0;
        end else begin
            tag_req_q <= hit_op & ~force_tag_q & bkpt_en_q;
        end
    end

    // without permit a breakpoint becomes a software interrupt
    always_ff @(posedge mclk) begin
        if (rst) begin
            swi_req_q <= 1'b0;
        end else begin
            swi_req_q <= ~permit_q & (mode_q == BDSC_MODE_RUN)
                       & (force_pend_q & cpu_boundary | cpu_tag_retire);
        end
    end

    // mode machine: request, wait for cpu halt, leave on go
    always_ff @(posedge mclk) begin
        if (rst) begin
            mode_q <= BDSC_MODE_RUN;
        end else begin
            case (mode_q)
                BDSC_MODE_RUN: begin
                    if (enter) begin
                        mode_q <= BDSC_MODE_ENTERING;
                    end
                end
                BDSC_MODE_ENTERING: begin
                    if (cpu_bdm_ack) begin
                        mode_q <= BDSC_MODE_BACKGROUND;
                    end
                end
                BDSC_MODE_BACKGROUND: begin
                    if (do_go) begin
                        mode_q <= BDSC_MODE_RUN;
                    end
                end
                default: begin
                    mode_q <= BDSC_MODE_RUN;
                end
            endcase
        end
    end

    // entry request held until the cpu acknowledges; it also wakes a
    // cpu out of wait or stop when it came from the background command
    always_ff @(posedge mclk) begin
        if (rst) begin
            bdm_req_q <= 1'b0;
        end else if (enter) begin
            bdm_req_q <= 1'b1;
        end else if (cpu_bdm_ack) begin
            bdm_req_q <= 1'b0;
        end
    end

    // registered copy of the active flag for the cpu side
    always_ff @(posedge mclk) begin
        if (rst) begin
            bdm_active_q <= 1'b0;
        end else begin
            bdm_active_q <= (mode_q == BDSC_MODE_ENTERING) ? cpu_bdm_ack
                          : (in_bg & ~do_go);
        end
    end

    // one-cycle resume pulse back to the cpu
    always_ff @(posedge mclk) begin
        if (rst) begin
            resume_q <= 1'b0;
        end else begin
            resume_q <= do_go;
        end
    end

    // remember that background was reached out of wait or stop
    always_ff @(posedge mclk) begin
        if (rst || do_go) begin
            ws_wake_q <= 1'b0;
        end else if (enter && do_bgnd_cmd && cpu_wait_stop) begin
            ws_wake_q <= 1'b1;
        end
    end

    // failure flag: a clash sets it, the next memory command start clears
    // it; a clash in the same cycle as a start still sets it
    always_ff @(posedge mclk) begin
        if (rst) begin
            ws_fail_q <= 1'b0;
        end else if (mem_ws_fail) begin
            ws_fail_q <= 1'b1;
        end else if (mem_cmd_start) begin
            ws_fail_q <= 1'b0;
        end
    end
endmodule : bdsc_ctrl
`default_nettype wire

// ### sim/bdsc_ctrl_props.sv
// Purpose: concurrent checks on the ports of the status/control block
// Assumes: one clock domain, reset synchronous and active high
// Notes:   status fields are judged on the read answer only
`timescale 1ns/1ps
`default_nettype none
module bdsc_ctrl_props
    import bdsc_pkg::*;
#(
    parameter int AW = BDSC_BKPT_W   // address width
) (
    input wire logic          mclk,           // system clock
    input wire logic          rst,            // synchronous reset
    input wire bdsc_cmd_t     cmd,            // serial command
    input wire logic          cpu_wait_stop,  // cpu in wait or stop
    input wire logic          cpu_bdm_ack,    // cpu has halted
    input wire logic          rsp_valid_q,    // read answer strobe
    input wire logic [AW-1:0] rsp_data_q,     // read answer data
    input wire logic          cmd_refused_q,  // refusal strobe
    input wire logic          bdm_req_q,      // background request
    input wire logic          resume_q,       // resume pulse
    input wire logic          bdm_active_q    // background active
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    chk_read_answer: assert property (cmd == BDSC_CMD_STATUS_READ |=> rsp_valid_q)
        else $error("status read not answered");
    chk_stat_active: assert property (cmd == BDSC_CMD_STATUS_READ |=> rsp_data_q[6] == $past(bdm_active_q))
        else $error("active bit differs from mode");
    chk_stat_unused: assert property (cmd == BDSC_CMD_STATUS_READ |=> rsp_data_q[AW-1:8] == '0 && !rsp_data_q[0])
        else $error("unused status bits set");
    chk_stat_ws: assert property (cmd == BDSC_CMD_STATUS_READ && cpu_wait_stop |=> rsp_data_q[2])
        else $error("wait stop bit clear in wait stop");
    chk_req_holds: assert property (bdm_req_q && !cpu_bdm_ack |=> bdm_req_q)
        else $error("request dropped before halt");
    chk_ack_active: assert property (bdm_req_q && cpu_bdm_ack |=> bdm_active_q && !bdm_req_q)
        else $error("halt did not activate mode");
    chk_active_stays: assert property (bdm_active_q && cmd != BDSC_CMD_GO |=> bdm_active_q)
        else $error("mode left without go");
    chk_go_resume: assert property (cmd == BDSC_CMD_GO && bdm_active_q |=> resume_q && !bdm_active_q)
        else $error("go did not resume");
    chk_refuse_ws: assert property ((cmd inside {BDSC_CMD_BKPT_READ, BDSC_CMD_BKPT_WRITE}) && cpu_wait_stop
        && !bdm_active_q |=> cmd_refused_q && !rsp_valid_q)
        else $error("command not refused in wait stop");

    // main scenarios reached
    cov_entry: cover property (bdm_req_q ##1 bdm_active_q);
    cov_refuse: cover property (cmd_refused_q);
    cov_resume: cover property (resume_q);
endmodule : bdsc_ctrl_props

bind bdsc_ctrl bdsc_ctrl_props #(.AW(AW)) i_props (.mclk(mclk), .rst(rst), .cmd(cmd),
    .cpu_wait_stop(cpu_wait_stop), .cpu_bdm_ack(cpu_bdm_ack), .rsp_valid_q(rsp_valid_q), .rsp_data_q(rsp_data_q),
    .cmd_refused_q(cmd_refused_q), .bdm_req_q(bdm_req_q), .resume_q(resume_q), .bdm_active_q(bdm_active_q));
`default_nettype wire

// ### sim/bdsc_cpu_model.sv
// Purpose: cpu side partner that halts when background entry is requested
// Assumes: request stays high until the halt pulse is seen
// Notes:   slow mode delays the halt to expose request holding
`timescale 1ns/1ps
`default_nettype none
module bdsc_cpu_model (
    input  wire logic mclk,         // system clock
    input  wire logic rst,          // synchronous reset
    input  wire logic bdm_req_q,    // entry request from block
    input  wire logic slow,         // 1 halts after three cycles
    output var  logic cpu_bdm_ack   // one-cycle halt pulse
);
    logic [1:0] wait_q;  // cycles the request has waited

    // halt pulse once the request has waited long enough
    always_ff @(posedge mclk) begin
        if (rst || !bdm_req_q || cpu_bdm_ack) begin
            wait_q      <= 2'h0;
            cpu_bdm_ack <= 1'b0;
        end else begin
            wait_q      <= wait_q + 2'h1;
            cpu_bdm_ack <= (wait_q >= (slow ? 2'h2 : 2'h0));
        end
    end
endmodule : bdsc_cpu_model
`default_nettype wire

// ### sim/bdsc_ctrl_tb.sv
// Purpose: self-checking bench of the status/control block
// Assumes: commands one cycle wide, one idle cycle between them
// Notes:   alternate link divide kept at 4, ticks counted over 8 cycles
`timescale 1ns/1ps
`default_nettype none
module bdsc_ctrl_tb
    import bdsc_pkg::*;
;
    logic        mclk, rst, slow;                               // clock, reset, partner speed
    bdsc_cmd_t   cmd;                                           // serial command
    logic [15:0] cmd_wdata, cpu_addr, rsp_data_q;               // data and address
    logic        mem_ws_fail, mem_cmd_start, cpu_wait_stop;     // memory command status
    logic        cpu_addr_valid, cpu_opfetch, cpu_boundary;     // cpu bus
    logic        cpu_tag_retire, cpu_bdm_ack;                   // cpu events
    logic        rsp_valid_q, cmd_refused_q, bdm_req_q;         // answers
    logic        swi_req_q, resume_q, tag_req_q, bdm_active_q;  // cpu requests
    logic        link_tick_q;                                   // link enable
    int          err_count = 0, total_checks = 0;               // counters

    bdsc_ctrl #(.AW(16), .ALT_DIV(4)) i_dut (.mclk(mclk), .rst(rst), .cmd(cmd), .cmd_wdata(cmd_wdata),
        .mem_ws_fail(mem_ws_fail), .mem_cmd_start(mem_cmd_start), .cpu_wait_stop(cpu_wait_stop),
        .cpu_addr_valid(cpu_addr_valid), .cpu_opfetch(cpu_opfetch), .cpu_addr(cpu_addr),
        .cpu_boundary(cpu_boundary), .cpu_tag_retire(cpu_tag_retire), .cpu_bgnd_exec(1'b0),
        .cpu_bdm_ack(cpu_bdm_ack), .rsp_valid_q(rsp_valid_q), .rsp_data_q(rsp_data_q),
        .cmd_refused_q(cmd_refused_q), .bdm_req_q(bdm_req_q), .swi_req_q(swi_req_q), .resume_q(resume_q),
        .tag_req_q(tag_req_q), .bdm_active_q(bdm_active_q), .link_tick_q(link_tick_q));
    bdsc_cpu_model i_cpu (.mclk(mclk), .rst(rst), .bdm_req_q(bdm_req_q), .slow(slow), .cpu_bdm_ack(cpu_bdm_ack));

    // free running 200 MHz clock
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : complete_run

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // one command cycle, returns just after the answer edge
    task automatic issue(input bdsc_cmd_t c, input logic [15:0] wd);
        @(posedge mclk);
        cmd       <= c;
        cmd_wdata <= wd;
        @(posedge mclk);
        cmd       <= BDSC_CMD_NONE;
        #1;
    endtask : issue

    task automatic rd(input logic [15:0] exp);
        issue(BDSC_CMD_STATUS_READ, 16'h0000);
        chk(rsp_valid_q, 1'b1);
        chk(rsp_data_q, exp);
    endtask : rd

    // bounded wait for background mode
    task automatic wait_act();
        repeat (10) if (bdm_active_q !== 1'b1) begin
            @(posedge mclk);
            #1;
        end
        chk(bdm_active_q, 1'b1);
    endtask : wait_act

    // one bus cycle at the breakpoint, optional boundary
    task automatic addr_cycle(input logic opf, input logic bnd);
        @(posedge mclk);
        cpu_addr_valid <= 1'b1;
        cpu_opfetch    <= opf;
        cpu_addr       <= 16'h1234;
        @(posedge mclk);
        cpu_addr_valid <= 1'b0;
        cpu_opfetch    <= 1'b0;
        @(posedge mclk);
        #1;
        chk(bdm_req_q, 1'b0);
        if (bnd) begin
            @(posedge mclk);
            cpu_boundary <= 1'b1;
            @(posedge mclk);
            cpu_boundary <= 1'b0;
            #1;
        end
    endtask : addr_cycle

    task automatic ticks(input logic [15:0] exp);
        logic [15:0] n = 16'h0000;
        repeat (4) @(posedge mclk);
        repeat (8) begin
            @(posedge mclk);
            #1;
            n += (link_tick_q === 1'b1);
        end
        chk(n, exp);
    endtask : ticks

    task automatic t_regs();
        rd(16'h0000);
        issue(BDSC_CMD_CONTROL_WRITE, 16'h00FF);
        rd(16'h00B8);
        ticks(16'h0008);
        issue(BDSC_CMD_CONTROL_WRITE, 16'h0000);
        ticks(16'h0002);
        issue(BDSC_CMD_BKPT_WRITE, 16'hA55A);
        issue(BDSC_CMD_BKPT_READ, 16'h0000);
        chk(rsp_data_q, 16'hA55A);
        issue(BDSC_CMD_BKPT_WRITE, 16'h1234);
        $display("test regs done");
    endtask : t_regs

    task automatic t_bgnd();
        issue(BDSC_CMD_BACKGROUND, 16'h0000);
        repeat (4) @(posedge mclk);
        #1;
        chk(bdm_req_q | bdm_active_q, 1'b0);
        issue(BDSC_CMD_CONTROL_WRITE, 16'h0080);
        issue(BDSC_CMD_BACKGROUND, 16'h0000);
        wait_act();
        rd(16'h00C0);
        issue(BDSC_CMD_CONTROL_WRITE, 16'h0008);
        rd(16'h00C8);
        issue(BDSC_CMD_GO, 16'h0000);
        chk({resume_q, bdm_active_q}, 16'h0002);
        $display("test background done");
    endtask : t_bgnd

    task automatic t_break();
        slow <= 1'b1;
        issue(BDSC_CMD_CONTROL_WRITE, 16'h00B0);
        addr_cycle(1'b0, 1'b1);
        chk(bdm_req_q, 1'b1);
        wait_act();
        issue(BDSC_CMD_GO, 16'h0000);
        slow <= 1'b0;
        issue(BDSC_CMD_CONTROL_WRITE, 16'h00A0);
        addr_cycle(1'b1, 1'b0);
        chk(tag_req_q, 1'b1);
        @(posedge mclk);
        cpu_tag_retire <= 1'b1;
        @(posedge mclk);
        cpu_tag_retire <= 1'b0;
        wait_act();
        issue(BDSC_CMD_GO, 16'h0000);
        issue(BDSC_CMD_CONTROL_WRITE, 16'h0090);
        addr_cycle(1'b0, 1'b1);
        chk({bdm_req_q, swi_req_q}, 16'h0000);
        issue(BDSC_CMD_CONTROL_WRITE, 16'h0030);
        addr_cycle(1'b0, 1'b1);
        chk(swi_req_q, 1'b1);
        @(posedge mclk);
        #1;
        chk({swi_req_q, bdm_active_q}, 16'h0000);
        $display("test breakpoint done");
    endtask : t_break

    task automatic t_wait();
        issue(BDSC_CMD_CONTROL_WRITE, 16'h0080);
        cpu_wait_stop <= 1'b1;
        issue(BDSC_CMD_BKPT_READ, 16'h0000);
        chk({cmd_refused_q, rsp_valid_q}, 16'h0002);
        rd(16'h0084);
        @(posedge mclk);
        mem_ws_fail <= 1'b1;
        @(posedge mclk);
        mem_ws_fail <= 1'b0;
        rd(16'h0086);
        issue(BDSC_CMD_BACKGROUND, 16'h0000);
        wait_act();
        cpu_wait_stop <= 1'b0;
        rd(16'h00C6);
        issue(BDSC_CMD_BKPT_READ, 16'h0000);
        chk(rsp_data_q, 16'h1234);
        @(posedge mclk);
        mem_cmd_start <= 1'b1;
        @(posedge mclk);
        mem_cmd_start <= 1'b0;
        rd(16'h00C4);
        issue(BDSC_CMD_GO, 16'h0000);
        rd(16'h0080);
        $display("test wait stop done");
    endtask : t_wait

    // watchdog, far beyond the test length
    initial begin
        repeat (5000) @(posedge mclk);
        err_count++;
        complete_run();
    end

    // main sequence, all inputs defined at time zero
    initial begin
        {rst, slow, mem_ws_fail, mem_cmd_start, cpu_wait_stop} = 5'h10;
        {cpu_addr_valid, cpu_opfetch, cpu_boundary, cpu_tag_retire} = 4'h0;
        {cmd_wdata, cpu_addr} = 32'h0000EDCB;
        cmd = BDSC_CMD_NONE;
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        t_regs();
        t_bgnd();
        t_break();
        t_wait();
        complete_run();
    end
endmodule : bdsc_ctrl_tb
`default_nettype wire
